/* File: include/audio_tx_pkg.sv */
// constants and types shared by the audio serial transmitter
package audio_tx_pkg;
   // ---------------------------------------------
   // word and buffer shape
   // ---------------------------------------------
   localparam int WORD_BITS = 32;
   localparam int FIFO_DEPTH = 32;
   localparam logic [4:0] LAST_BIT = 5'h1F;
   // ---------------------------------------------
   // clock and detection widths
   // ---------------------------------------------
   localparam int CLOCK_HZ = 50000000;
   localparam int RATIO_BITS = 10;
   localparam int PERIOD_BITS = 16;
   // ---------------------------------------------
   // format pin codes {high, low}
   // ---------------------------------------------
   localparam logic [1:0] FMT_TDM4 = 2'h0;
   localparam logic [1:0] FMT_TDM2 = 2'h1;
   localparam logic [1:0] FMT_LEFT = 2'h2;
   localparam logic [1:0] FMT_I2S = 2'h3;
   localparam logic [2:0] SLOTS_TDM4 = 3'h4;
   localparam logic [2:0] SLOTS_TDM2 = 3'h2;
   // ---------------------------------------------
   // master clock generation
   // ---------------------------------------------
   localparam logic [9:0] RATIO_TDM4 = 10'h080;
   localparam logic [9:0] RATIO_2CH = 10'h040;
   localparam logic [9:0] HALF_2CH = 10'h020;
   // system clock edges per half bit clock: 256x and 512x references
   localparam logic [2:0] HALF_TDM4_256 = 3'h1;
   localparam logic [2:0] HALF_TDM4_512 = 3'h2;
   localparam logic [2:0] HALF_2CH_256 = 3'h2;
   localparam logic [2:0] HALF_2CH_512 = 3'h4;
   // ---------------------------------------------
   // pin synchroniser bit positions
   // ---------------------------------------------
   localparam int PIN_ROLE = 0;
   localparam int PIN_FMT_LO = 1;
   localparam int PIN_FMT_HI = 2;
   localparam int PIN_OPT = 3;
   localparam int PIN_SYS = 4;
   localparam int PIN_BCLK = 5;
   localparam int PIN_FS = 6;
   localparam int PIN_COUNT = 7;

   typedef enum logic {wait_idle, wait_fall} i2s_wait_type;
endpackage : audio_tx_pkg

/* File: verilog/sample_fifo.sv */
// sample fifo with registered read data
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = audio_tx_pkg::WORD_BITS,
   parameter int DEPTH = audio_tx_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_enable,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic in_ready_reg;
   logic out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;

   wire write_now = in_valid & in_ready_reg;
   // output register refills whenever it is empty or being taken
   wire read_now = (count_reg != '0) & (~out_valid_reg | out_ready);
   assign count_next = count_reg + {{AW{1'b0}}, write_now} - {{AW{1'b0}}, read_now};
   assign in_ready = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;

   always_ff @(posedge clock) begin
      if (clock_enable && write_now) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready_reg <= 1'b0;
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end else if (clock_enable) begin
         wr_ptr_reg <= wr_ptr_reg + AW'(write_now);
         rd_ptr_reg <= rd_ptr_reg + AW'(read_now);
         count_reg <= count_next;
         in_ready_reg <= (count_next < (AW+1)'(DEPTH));
         if (read_now) begin
            out_data_reg <= mem[rd_ptr_reg];
            out_valid_reg <= 1'b1;
         end else if (out_ready) begin
            out_valid_reg <= 1'b0;
         end
      end
   end
endmodule : sample_fifo
`default_nettype wire

/* File: verilog/audio_serial_tx.sv */
// pin-configured audio serial transmitter: tdm, i2s and left-justified
`timescale 1ns/100ps
`default_nettype none
// Function
// - slave takes clocks, master drives them
// - role pin low slave, high master
// - format pins pick tdm4, tdm2, left, i2s
// - 32-bit words, most significant bit first
// - tdm frame starts at sync rise, slot0 first
// - tdm bits launch on bit clock rise
// - zeros after the active slot data
// - any whole-cycle sync width accepted
// - i2s msb on second falling edge
// - i2s and left-justified bits launch on fall, but the left-justified msb launches at the sync edge, on the rise as master
// - master sync changes on bit clock rise
// - left-justified msb right after sync edge
// - slave detects ratio and frame period
// - master reference is 256x or 512x
module audio_serial_tx (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_enable,
   input wire logic bus_role_select,
   input wire logic format_select_high,
   input wire logic format_select_low,
   input wire logic filter_or_sysclk_option_pin,
   input wire logic system_clock_input_pin,
   input wire logic bit_clock_in,
   output logic bit_clock_out,
   output logic bit_clock_oe,
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe,
   output logic serial_data_out,
   input wire logic [31:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic [9:0] detected_ratio,
   output logic [15:0] detected_frame_cycles,
   output logic detect_valid,
   output logic low_latency_filter,
   output logic underrun
);
   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [audio_tx_pkg::PIN_COUNT-1:0] sync1_reg;
   logic [audio_tx_pkg::PIN_COUNT-1:0] sync2_reg;
   wire [audio_tx_pkg::PIN_COUNT-1:0] pins = {frame_sync_in, bit_clock_in,
      system_clock_input_pin, filter_or_sysclk_option_pin, format_select_high,
      format_select_low, bus_role_select};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else if (clock_enable) begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
      end
   end

   // ---------------------------------------------
   // configuration decode
   // ---------------------------------------------
   // role pin level
   wire master = sync2_reg[audio_tx_pkg::PIN_ROLE];
   wire opt_high = sync2_reg[audio_tx_pkg::PIN_OPT];
   wire [1:0] fmt = {sync2_reg[audio_tx_pkg::PIN_FMT_HI], sync2_reg[audio_tx_pkg::PIN_FMT_LO]};
   wire fmt_tdm = (fmt == audio_tx_pkg::FMT_TDM4) | (fmt == audio_tx_pkg::FMT_TDM2);
   wire fmt_left = (fmt == audio_tx_pkg::FMT_LEFT);
   wire fmt_i2s = (fmt == audio_tx_pkg::FMT_I2S);
   // channels one to four in slots zero to three
   wire [2:0] slots = (fmt == audio_tx_pkg::FMT_TDM4) ? audio_tx_pkg::SLOTS_TDM4 :
      audio_tx_pkg::SLOTS_TDM2;
   wire [9:0] ratio = (fmt == audio_tx_pkg::FMT_TDM4) ? audio_tx_pkg::RATIO_TDM4 :
      audio_tx_pkg::RATIO_2CH;
   // half period in reference edges per multiple
   wire [2:0] half_limit = (fmt == audio_tx_pkg::FMT_TDM4) ?
      (opt_high ? audio_tx_pkg::HALF_TDM4_512 : audio_tx_pkg::HALF_TDM4_256) :
      (opt_high ? audio_tx_pkg::HALF_2CH_512 : audio_tx_pkg::HALF_2CH_256);

   // ---------------------------------------------
   // master clock and frame generation
   // ---------------------------------------------
   logic sys_prev_reg;
   logic [2:0] half_cnt_reg;
   logic [9:0] bit_idx_reg;
   logic bclk_gen_reg;
   logic fs_gen_reg;
   logic oe_reg;
   wire sys_rise = sync2_reg[audio_tx_pkg::PIN_SYS] & ~sys_prev_reg;
   wire half_done = sys_rise & (half_cnt_reg == half_limit - 3'h1);
   wire gen_rise = master & half_done & ~bclk_gen_reg;
   wire [9:0] bit_idx_next = (bit_idx_reg >= ratio - 10'h001) ? 10'h000 : bit_idx_reg + 10'h001;
   // sync level chosen for the rising edge about to happen
   wire fs_gen_next = fmt_tdm ? (bit_idx_next == 10'h000) :
      fmt_left ? (bit_idx_next < audio_tx_pkg::HALF_2CH) :
      (bit_idx_next >= audio_tx_pkg::HALF_2CH);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sys_prev_reg <= 1'b0;
         half_cnt_reg <= 3'h0;
         bit_idx_reg <= 10'h3FF;
         bclk_gen_reg <= 1'b0;
         fs_gen_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (clock_enable) begin
         sys_prev_reg <= sync2_reg[audio_tx_pkg::PIN_SYS];
         // drive clock pins only as master
         oe_reg <= master;
         if (!master) begin
            half_cnt_reg <= 3'h0;
            bclk_gen_reg <= 1'b0;
         end else if (half_done) begin
            half_cnt_reg <= 3'h0;
            bclk_gen_reg <= ~bclk_gen_reg;
         end else if (sys_rise) begin
            half_cnt_reg <= half_cnt_reg + 3'h1;
         end
         if (gen_rise) begin
            // sync moves with the bit clock rise
            bit_idx_reg <= bit_idx_next;
            fs_gen_reg <= fs_gen_next;
         end
      end
   end

   // ---------------------------------------------
   // link edge detection
   // ---------------------------------------------
   logic bclk_prev_reg;
   logic fs_prev_reg;
   // slave listens to the pins, master to its own lines
   wire bclk_cur = master ? bclk_gen_reg : sync2_reg[audio_tx_pkg::PIN_BCLK];
   wire fs_cur = master ? fs_gen_reg : sync2_reg[audio_tx_pkg::PIN_FS];
   wire bclk_rise = bclk_cur & ~bclk_prev_reg;
   wire bclk_fall = ~bclk_cur & bclk_prev_reg;
   wire fs_rise = fs_cur & ~fs_prev_reg;
   wire fs_fall = ~fs_cur & fs_prev_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bclk_prev_reg <= 1'b0;
         fs_prev_reg <= 1'b0;
      end else if (clock_enable) begin
         bclk_prev_reg <= bclk_cur;
         fs_prev_reg <= fs_cur;
      end
   end

   // ---------------------------------------------
   // slave rate detection
   // ---------------------------------------------
   logic [9:0] ratio_cnt_reg;
   logic [15:0] period_cnt_reg;
   logic [9:0] ratio_reg;
   logic [15:0] period_reg;
   logic det_valid_reg;
   logic filter_reg;

   // counters saturate, but the period latch adds one, so a stalled link reads zero period, a wrap
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ratio_cnt_reg <= 10'h000;
         period_cnt_reg <= 16'h0000;
         ratio_reg <= 10'h000;
         period_reg <= 16'h0000;
         det_valid_reg <= 1'b0;
         filter_reg <= 1'b0;
      end else if (clock_enable) begin
         filter_reg <= ~master & opt_high;
         if (master) begin
            det_valid_reg <= 1'b0;
            ratio_cnt_reg <= 10'h000;
            period_cnt_reg <= 16'h0000;
         end else if (fs_rise) begin
            // latch ratio and frame period per frame
            ratio_reg <= ratio_cnt_reg + 10'(bclk_rise);
            period_reg <= period_cnt_reg + 16'h0001;
            det_valid_reg <= 1'b1;
            ratio_cnt_reg <= 10'h000;
            period_cnt_reg <= 16'h0000;
         end else begin
            if (bclk_rise && ratio_cnt_reg != 10'h3FF) begin
               ratio_cnt_reg <= ratio_cnt_reg + 10'h001;
            end
            if (period_cnt_reg != 16'hFFFF) begin
               period_cnt_reg <= period_cnt_reg + 16'h0001;
            end
         end
      end
   end

   // ---------------------------------------------
   // sample buffer
   // ---------------------------------------------
   logic [31:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;

   sample_fifo #(
      .WIDTH(audio_tx_pkg::WORD_BITS),
      .DEPTH(audio_tx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .clock_enable(clock_enable),
      .in_data(sample_data),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // ---------------------------------------------
   // serialiser
   // ---------------------------------------------
   audio_tx_pkg::i2s_wait_type wait_reg;
   logic fall_cnt_reg;
   logic active_reg;
   logic [30:0] shift_reg;
   logic [4:0] bits_left_reg;
   logic [2:0] slots_left_reg;
   logic sdo_reg;
   logic underrun_reg;

   // tdm launches on rise; others on fall
   wire launch = fmt_tdm ? bclk_rise : bclk_fall;
   // tdm frame opens on sync rise, width ignored
   // only the edge matters, not the pulse width
   wire start_tdm = fmt_tdm & fs_rise;
   // left-justified word opens at either sync edge
   wire start_left = fmt_left & (fs_rise | fs_fall);
   // i2s msb on the second falling edge after a sync edge
   wire start_i2s = fmt_i2s & (wait_reg == audio_tx_pkg::wait_fall) & bclk_fall & fall_cnt_reg;
   wire arm_i2s = fmt_i2s & (fs_rise | fs_fall);
   wire start_now = start_tdm | start_left | start_i2s;
   wire word_done = active_reg & launch & (bits_left_reg == 5'h00) & ~start_now;
   wire chain_now = word_done & (slots_left_reg != 3'h0);
   wire stop_now = word_done & (slots_left_reg == 3'h0);
   wire shift_now = active_reg & launch & (bits_left_reg != 5'h00) & ~start_now;
   wire load_now = start_now | chain_now;
   // a missing sample goes out as zeros
   wire [31:0] word = fifo_valid ? fifo_data : 32'h0000_0000;
   assign fifo_pop = clock_enable & load_now & fifo_valid;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= audio_tx_pkg::wait_idle;
         fall_cnt_reg <= 1'b0;
      end else if (clock_enable) begin
         if (arm_i2s) begin
            wait_reg <= audio_tx_pkg::wait_fall;
            fall_cnt_reg <= 1'b0;
         end else begin
            case (wait_reg)
               audio_tx_pkg::wait_fall: begin
                  if (start_i2s || !fmt_i2s) begin
                     wait_reg <= audio_tx_pkg::wait_idle;
                  end else if (bclk_fall) begin
                     fall_cnt_reg <= 1'b1;
                  end
               end
               default: begin
                  wait_reg <= audio_tx_pkg::wait_idle;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         active_reg <= 1'b0;
         shift_reg <= '0;
         bits_left_reg <= 5'h00;
         slots_left_reg <= 3'h0;
         sdo_reg <= 1'b0;
         underrun_reg <= 1'b0;
      end else if (clock_enable) begin
         underrun_reg <= load_now & ~fifo_valid;
         if (load_now) begin
            // msb first, 32 bits a slot
            active_reg <= 1'b1;
            sdo_reg <= word[31];
            shift_reg <= word[30:0];
            bits_left_reg <= audio_tx_pkg::LAST_BIT;
            // remaining tdm slots follow in order
            slots_left_reg <= start_now ? (fmt_tdm ? slots - 3'h1 : 3'h0) :
               slots_left_reg - 3'h1;
         end else if (shift_now) begin
            sdo_reg <= shift_reg[30];
            shift_reg <= {shift_reg[29:0], 1'b0};
            bits_left_reg <= bits_left_reg - 5'h01;
         end else if (stop_now) begin
            active_reg <= 1'b0;
            sdo_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign bit_clock_out = bclk_gen_reg;
   assign frame_sync_out = fs_gen_reg;
   assign bit_clock_oe = oe_reg;
   assign frame_sync_oe = oe_reg;
   assign serial_data_out = sdo_reg;
   assign detected_ratio = ratio_reg;
   assign detected_frame_cycles = period_reg;
   assign detect_valid = det_valid_reg;
   assign low_latency_filter = filter_reg;
   assign underrun = underrun_reg;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_master_drives;
      clock_enable && master |=> bit_clock_oe && frame_sync_oe;
   endproperty
   a_master_drives: assert property (p_master_drives) else $error("master not driving");

   property p_slave_floats;
      clock_enable && !master |=> !bit_clock_oe ##0 !frame_sync_oe;
   endproperty
   a_slave_floats: assert property (p_slave_floats) else $error("slave drives clocks");

   property p_tdm4_slots;
      clock_enable && start_tdm && fmt == audio_tx_pkg::FMT_TDM4 |=> slots_left_reg == 3'h3;
   endproperty
   a_tdm4_slots: assert property (p_tdm4_slots) else $error("tdm4 slot count");

   property p_word_load;
      clock_enable && load_now |=> bits_left_reg == 5'h1F && serial_data_out == $past(word[31]);
   endproperty
   a_word_load: assert property (p_word_load) else $error("word msb not first");

   property p_idle_zero;
      !active_reg |-> !serial_data_out;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("data outside slots");

   property p_i2s_delay;
      clock_enable && arm_i2s |=> wait_reg == audio_tx_pkg::wait_fall && !fall_cnt_reg;
   endproperty
   a_i2s_delay: assert property (p_i2s_delay) else $error("i2s msb delay");

   property p_master_fs_edge;
      oe_reg && $changed(frame_sync_out) |-> $rose(bit_clock_out);
   endproperty
   a_master_fs_edge: assert property (p_master_fs_edge) else $error("sync off rise");

   property p_detect_frame;
      $rose(detect_valid) |-> $past(fs_rise) && !$past(master);
   endproperty
   a_detect_frame: assert property (p_detect_frame) else $error("detect without frame");

   property p_half_period;
      clock_enable && master && half_done |=> $changed(bit_clock_out) && half_cnt_reg == 3'h0;
   endproperty
   a_half_period: assert property (p_half_period) else $error("bit clock divider");

   c_tdm_frame: cover property (clock_enable && start_tdm && fifo_valid);
   c_i2s_word: cover property (clock_enable && start_i2s);
   c_left_word: cover property (clock_enable && start_left && fs_fall);
   c_underrun: cover property (underrun);
endmodule : audio_serial_tx
`default_nettype wire

/* File: sim/audio_host_model.sv */
// host model that clocks the serial link while the transmitter is a slave
`timescale 1ns/100ps
`default_nettype none
module audio_host_model #(
   parameter int HALF = 8
) (
   input wire logic clock,
   input wire logic [1:0] fmt,
   input wire logic [7:0] frames,
   input wire logic start,
   output logic bit_clock,
   output logic frame_sync,
   output logic sample_point,
   output logic busy
);
   int len;
   // ------
   // frame shape
   // ------
   // 160 or 80 clocks, halves of 40
   assign len = (fmt == audio_tx_pkg::FMT_TDM4) ? 160 : 80;

   initial begin
      bit_clock = 1'h0;
      frame_sync = 1'h0;
      sample_point = 1'h0;
      busy = 1'h0;
   end

   task automatic edge_wait();
      @(posedge clock);
      sample_point <= 1'h0;
      repeat (HALF - 1) @(posedge clock);
   endtask : edge_wait

   // ------
   // frame generator
   // ------
   // bit clock stands low between bursts, like a real host that gates it
   always begin
      @(posedge clock);
      if (start !== 1'h1) begin
         // idle sync level held static per format
         frame_sync <= (fmt == audio_tx_pkg::FMT_I2S);
      end else begin
         busy <= 1'h1;
         for (int f = 0; f < frames; f++) begin
            for (int n = 0; n < len; n++) begin
               bit_clock <= 1'h1;
               // tdm sync one or three clocks wide
               if (!fmt[1]) frame_sync <= (n < (fmt[0] ? 3 : 1));
               if (fmt == audio_tx_pkg::FMT_I2S) frame_sync <= (n >= len / 2);
               // two-channel data is taken on the rise, tdm on the fall
               sample_point <= fmt[1];
               edge_wait();
               bit_clock <= 1'h0;
               if (fmt == audio_tx_pkg::FMT_LEFT) frame_sync <= (n < len / 2);
               sample_point <= !fmt[1];
               edge_wait();
            end
         end
         busy <= 1'h0;
      end
   end
endmodule : audio_host_model
`default_nettype wire

/* File: sim/pin_configured_audio_serial_tx_tb.sv */
// self-checking bench for the pin-configured audio serial transmitter
`timescale 1ns/100ps
`default_nettype none
module pin_configured_audio_serial_tx_tb;
   logic clock, rst_n, role, fmt_hi, fmt_lo, opt, ref_clk, bclk_pin, fs_pin, start;
   logic sample_valid, sample_ready, bit_clock_out, bit_clock_oe, frame_sync_out;
   logic frame_sync_oe, serial_data_out, detect_valid, underrun, low_latency_filter, exp_bit;
   logic host_bclk, host_fs, sample_point, host_busy;
   logic [31:0] sample_data;
   logic [9:0] detected_ratio;
   logic [15:0] detected_frame_cycles;
   logic [7:0] frames;
   logic exp_q[$];
   logic [31:0] words[$];
   int mismatches, num_checks, underruns, ref_count, u;

   // ------
   // wires and instances
   // ------
   assign bclk_pin = bit_clock_oe ? bit_clock_out : host_bclk;
   assign fs_pin = frame_sync_oe ? frame_sync_out : host_fs;

   audio_serial_tx dut (.clock, .rst_n, .clock_enable(1'h1), .bus_role_select(role),
      .format_select_high(fmt_hi), .format_select_low(fmt_lo),
      .filter_or_sysclk_option_pin(opt), .system_clock_input_pin(ref_clk),
      .bit_clock_in(bclk_pin), .bit_clock_out, .bit_clock_oe, .frame_sync_in(fs_pin),
      .frame_sync_out, .frame_sync_oe, .serial_data_out, .sample_data, .sample_valid,
      .sample_ready, .detected_ratio, .detected_frame_cycles, .detect_valid,
      .low_latency_filter, .underrun);

   audio_host_model #(.HALF(8)) host (.clock, .fmt({fmt_hi, fmt_lo}), .frames, .start,
      .bit_clock(host_bclk), .frame_sync(host_fs), .sample_point, .busy(host_busy));

   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end

   // 5 MHz reference, well under the sampling limit of the pin
   initial begin
      ref_clk = 1'h0;
      forever #100 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) ref_count++;
   always @(posedge clock) if (underrun === 1'h1) underruns++;

   // ------
   // checking
   // ------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      if (mismatches == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   always @(posedge clock) begin
      if (sample_point === 1'h1) begin
         exp_bit = (exp_q.size() > 0) ? exp_q.pop_front() : 1'hx;
         check(serial_data_out, exp_bit);
      end
   end

   // ------
   // drivers
   // ------
   task automatic set_pins(input logic r, input logic [1:0] f, input logic o);
      role <= r;
      {fmt_hi, fmt_lo} <= f;
      opt <= o;
      repeat (20) @(posedge clock);
   endtask : set_pins

   task automatic push_words(input int n);
      logic [31:0] w;
      for (int i = 0; i < n; i++) begin
         w = $urandom;
         words.push_back(w);
         sample_data <= w;
         sample_valid <= 1'h1;
         do @(posedge clock); while (sample_ready !== 1'h1);
      end
      sample_valid <= 1'h0;
   endtask : push_words

   // an empty fifo at a slot start means a slot of zeros
   task automatic burst(input int nf);
      logic [31:0] w[4];
      int s, sl, len, off, p;
      s = (!fmt_hi && !fmt_lo) ? 4 : 2;
      sl = fmt_hi ? 40 : 32;
      len = (s == 4) ? 160 : 80;
      off = fmt_hi ? (fmt_lo ? 2 : 1) : 0;
      for (int f = 0; f < nf; f++) begin
         for (int i = 0; i < 4; i++) begin
            w[i] = (i < s && words.size() > 0) ? words.pop_front() : 32'h0;
         end
         for (int n = 0; n < len; n++) begin
            p = (n - off + len) % len;
            exp_q.push_back((p / sl < s && p % sl < 32) ? w[p / sl][31 - p % sl] : 1'h0);
         end
      end
      frames <= nf[7:0];
      start <= 1'h1;
      @(posedge clock);
      start <= 1'h0;
      @(posedge clock);
      while (host_busy === 1'h1) @(posedge clock);
      repeat (10) @(posedge clock);
      check(exp_q.size(), 0);
   endtask : burst

   task automatic master(input logic [1:0] f, input logic o, input int half, input int ratio);
      int bc, c0, b0, fsr;
      logic pb, pf;
      set_pins(1'h1, f, o);
      repeat (300) @(posedge clock);
      check({bit_clock_oe, frame_sync_oe}, 2'h3);
      check(low_latency_filter, 1'h0);
      pb = bit_clock_out;
      pf = frame_sync_out;
      bc = 0;
      fsr = 0;
      for (int k = 0; k < 20000 && fsr < 2; k++) begin
         @(posedge clock);
         #1;
         if (frame_sync_out !== pf) check(bit_clock_out & ~pb, 1'h1);
         if (bit_clock_out && !pb) bc++;
         if (bit_clock_out && !pb && bc == 2) c0 = ref_count;
         if (bit_clock_out && !pb && bc == 3) check(ref_count - c0, 2 * half);
         if (frame_sync_out && !pf) begin
            fsr++;
            if (fsr == 1) b0 = bc;
            else check(bc - b0, ratio);
         end
         pb = bit_clock_out;
         pf = frame_sync_out;
      end
      check(fsr, 2);
      @(posedge clock);
   endtask : master

   // ------
   // main sequence
   // ------
   initial begin
      rst_n = 1'h0;
      role = 1'h0;
      fmt_hi = 1'h0;
      fmt_lo = 1'h0;
      opt = 1'h0;
      sample_data = 32'h0;
      sample_valid = 1'h0;
      start = 1'h0;
      frames = 8'h0;
      void'($urandom(32'h15CF));
      repeat (16) @(posedge clock);
      rst_n <= 1'h1;
      for (int f = 0; f < 4; f++) begin
         set_pins(1'h0, f[1:0], f[0]);
         check({bit_clock_oe, frame_sync_oe}, 2'h0);
         check(low_latency_filter, f[0]);
         u = underruns;
         burst(1);
         check(underruns > u, 1'h1);
         if (f == 0) begin
            // 32 words in the buffer plus one in its output register, then refused
            push_words(33);
            repeat (2) @(posedge clock);
            check(sample_ready, 1'h0);
            repeat (2) burst(4);
            check(detected_ratio, 10'h0A0);
            check(detected_frame_cycles, 16'h0A00);
            check(detect_valid, 1'h1);
         end else begin
            push_words(4);
            burst(2);
         end
      end
      master(2'h0, 1'h0, 1, 128);
      master(2'h3, 1'h1, 4, 64);
      end_sim();
   end

   initial begin
      repeat (90000) @(posedge clock);
      mismatches++;
      end_sim();
   end
endmodule : pin_configured_audio_serial_tx_tb
`default_nettype wire
